// *** rtl/rsc_low_counter.v ***
// Counts consecutive cycles of a level and flags when a threshold is reached.
`timescale 1ns/10ps
`default_nettype none
`include "rsc_map.vh"
module rsc_low_counter #(
   parameter [`RSC_CNT_W-1:0] LIMIT = 16'h0001
) (
   input  wire                  clk,
   input  wire                  rstn,
   input  wire                  level,
   output wire                  reached
);
   reg [`RSC_CNT_W-1:0] cnt_q;

   always @(posedge clk) begin
      if (!rstn) begin
         cnt_q <= {`RSC_CNT_W{1'b0}};
      end else if (!level) begin
         cnt_q <= {`RSC_CNT_W{1'b0}};
      end else if (cnt_q != LIMIT) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   assign reached = (cnt_q == LIMIT);
endmodule // rsc_low_counter
`default_nettype wire

// *** rtl/rsc_map.vh ***
// Timing constants and encodings for the reset source combiner.
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
// Shortest external low taken as a reset: 10 us at 40 MHz.
`define RSC_EXT_MIN_CYC      16'h0190
// Release delay after the supply settles: 100 us at 40 MHz.
`define RSC_REL_DELAY_CYC    16'h0FA0
`define RSC_CNT_W            16
`define RSC_PORT_W           2
// Port codes are {low select pin, high select pin}.
`define RSC_PORT_UART        2'h3
`define RSC_PORT_SPI         2'h2
`define RSC_PORT_BOOT        2'h1
`define RSC_PORT_I2C         2'h0
`define RSC_PIN_IDLE         1'b1
`define RSC_ST_RESET         2'h0
`define RSC_ST_RUN           2'h1
`define RSC_ST_SHUTDOWN      2'h2
`endif

// *** rtl/rsc_reset_combiner.v ***
// Reset source combiner: merges external, power-on and supply-fail resets.
`timescale 1ns/10ps
`default_nettype none
`include "rsc_map.vh"
// How it works
// - Reset pin is open-drain, sampled and pulled low.
// - Any single source alone forces reset.
// - Power-up holds pin low past threshold plus delay.
// - Supply dip resets; release after delay.
// - During reset other pins float with pull-ups.
// - Shutdown wakes only on a reset event.
// - Port select pins sampled on leaving reset.
module rsc_reset_combiner (
   input  wire                   clk,
   input  wire                   rstn,
   input  wire                   reset_pin_in,
   output wire                   reset_pin_out,
   output wire                   reset_pin_oe,
   input  wire                   supply_above_trip_threshold,
   input  wire                   shutdown_req,
   input  wire                   wake_req,
   input  wire                   host_port_select_lo,
   input  wire                   host_port_select_hi,
   output reg  [`RSC_PORT_W-1:0] host_port_q,
   output reg                    core_reset_q,
   output reg                    shutdown_q,
   output wire                   pins_hiz,
   output wire                   pins_pullup_en
);

   // =====================================================================
   // State codes
   localparam [1:0] ST_RESET    = `RSC_ST_RESET;
   localparam [1:0] ST_RUN      = `RSC_ST_RUN;
   localparam [1:0] ST_SHUTDOWN = `RSC_ST_SHUTDOWN;

   // =====================================================================
   // Internal signals
   reg                    pin_meta_q;
   reg                    pin_sync_q;
   wire                   ext_low;
   wire                   ext_reached;
   wire                   sup_stable;
   reg                    por_active_q;
   wire                   por_rst;
   wire                   fail_rst;
   wire                   internal_rst;
   wire                   any_rst;
   wire                   leave_reset;
   reg  [1:0]             state_q;
   reg  [1:0]             state_d;
   reg                    core_reset_d;
   reg                    shutdown_d;
   reg  [`RSC_PORT_W-1:0] host_port_d;

   // =====================================================================
   // Pin sampling
   // The pin is taken through two flip-flops before any decision uses it.
   always @(posedge clk) begin
      if (!rstn) begin
         pin_meta_q <= `RSC_PIN_IDLE;
         pin_sync_q <= `RSC_PIN_IDLE;
      end else begin
         pin_meta_q <= reset_pin_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   assign ext_low = !pin_sync_q;

   // =====================================================================
   // Low and settle counters
   // External request counts only a continuous low of the minimum length.
   rsc_low_counter #(
      .LIMIT (`RSC_EXT_MIN_CYC)
   ) u_ext_cnt (
      .clk     (clk),
      .rstn    (rstn),
      .level   (ext_low),
      .reached (ext_reached)
   );

   // Supply must stay above threshold for the release delay.
   rsc_low_counter #(
      .LIMIT (`RSC_REL_DELAY_CYC)
   ) u_sup_cnt (
      .clk     (clk),
      .rstn    (rstn),
      .level   (supply_above_trip_threshold),
      .reached (sup_stable)
   );

   // =====================================================================
   // Source combination
   // The power-on source holds until the supply settles for the first time.
   always @(posedge clk) begin
      if (!rstn) begin
         por_active_q <= 1'b1;
      end else if (sup_stable) begin
         por_active_q <= 1'b0;
      end
   end

   assign por_rst      = por_active_q & !sup_stable;
   assign fail_rst     = !por_active_q & !sup_stable;
   assign internal_rst = por_rst | fail_rst;
   assign any_rst      = internal_rst | ext_reached;

   // =====================================================================
   // State transitions
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RESET: begin
            if (!any_rst && pin_sync_q) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (any_rst) begin
               state_d = ST_RESET;
            end else if (shutdown_req) begin
               state_d = ST_SHUTDOWN;
            end
         end
         ST_SHUTDOWN: begin
            // Wake requests are ignored here; only a reset leaves.
            if (any_rst) begin
               state_d = ST_RESET;
            end
         end
         default: begin
            state_d = ST_RESET;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rstn) begin
         state_q <= ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // =====================================================================
   // Core reset and shutdown flags
   always @* begin
      core_reset_d = 1'b1;
      shutdown_d   = 1'b0;
      case (state_d)
         ST_RESET: begin
            core_reset_d = 1'b1;
            shutdown_d   = 1'b0;
         end
         ST_RUN: begin
            core_reset_d = 1'b0;
            shutdown_d   = 1'b0;
         end
         ST_SHUTDOWN: begin
            core_reset_d = 1'b0;
            shutdown_d   = 1'b1;
         end
         default: begin
            core_reset_d = 1'b1;
            shutdown_d   = 1'b0;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rstn) begin
         core_reset_q <= 1'b1;
      end else begin
         core_reset_q <= core_reset_d;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         shutdown_q <= 1'b0;
      end else begin
         shutdown_q <= shutdown_d;
      end
   end

   // =====================================================================
   // Host port capture
   // The select pins are read once, on the step out of reset.
   assign leave_reset = (state_q == ST_RESET) && (state_d == ST_RUN);

   always @* begin
      host_port_d = host_port_q;
      if (leave_reset) begin
         host_port_d = {host_port_select_lo, host_port_select_hi};
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         host_port_q <= `RSC_PORT_UART;
      end else begin
         host_port_q <= host_port_d;
      end
   end

   // =====================================================================
   // Pin drive
   // Only ever drives low; the pull-up outside supplies the high level.
   assign reset_pin_out  = 1'b0;
   assign reset_pin_oe   = internal_rst;
   assign pins_hiz       = core_reset_q | ext_low;
   assign pins_pullup_en = pins_hiz;

   // The wake input is unused by design outside shutdown as well.
   wire unused_wake = wake_req;
endmodule // rsc_reset_combiner
`default_nettype wire

// *** tb/rsc_checker.sv ***
// Port assertions for the reset source combiner.
`timescale 1ns/10ps
`default_nettype none
module rsc_checker (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       reset_pin_in,
   input wire logic       reset_pin_out,
   input wire logic       reset_pin_oe,
   input wire logic       supply_above_trip_threshold,
   input wire logic       core_reset_q,
   input wire logic       shutdown_q,
   input wire logic       pins_hiz,
   input wire logic       pins_pullup_en,
   input wire logic       host_port_select_lo,
   input wire logic       host_port_select_hi,
   input wire logic [1:0] host_port_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [15:0] pin_low_cnt;
   wire         sup = supply_above_trip_threshold;
   always @(posedge clk) begin
      pin_low_cnt <= (reset_pin_in || !rstn) ? 16'h0000 : pin_low_cnt + 16'h0001;
   end
   sequence s_dip; !sup; endsequence
   sequence s_hold; reset_pin_oe ##[0:2] core_reset_q; endsequence
   property p_od; reset_pin_out == 1'b0; endproperty
   property p_dip; s_dip |=> s_hold; endproperty
   property p_up; $rose(sup) |=> reset_pin_oe [*8]; endproperty
   property p_hz; core_reset_q || !$past(reset_pin_in, 2) |-> pins_hiz && pins_pullup_en;
   endproperty
   property p_sd; (shutdown_q && reset_pin_in && sup) [*4] |=> shutdown_q; endproperty
   property p_gl; !core_reset_q && sup && $past(sup) && pin_low_cnt < 16'h0186
      && $past(pin_low_cnt, 3) < 16'h0186 |=> !core_reset_q; endproperty
   property p_ext; pin_low_cnt == 16'h019A |-> core_reset_q; endproperty
   property p_port; $fell(core_reset_q) |->
      host_port_q == {$past(host_port_select_lo), $past(host_port_select_hi)}; endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   a_dip: assert property (p_dip) else $error("no reset on dip");
   a_up: assert property (p_up) else $error("early release");
   a_hz: assert property (p_hz) else $error("pins not floated");
   a_sd: assert property (p_sd) else $error("shutdown left");
   a_gl: assert property (p_gl) else $error("short low taken");
   a_ext: assert property (p_ext) else $error("long low missed");
   a_port: assert property (p_port) else $error("port not latched");
endmodule // rsc_checker
bind rsc_reset_combiner rsc_checker u_rsc_checker (
   .clk                         (clk),
   .rstn                        (rstn),
   .reset_pin_in                (reset_pin_in),
   .reset_pin_out               (reset_pin_out),
   .reset_pin_oe                (reset_pin_oe),
   .supply_above_trip_threshold (supply_above_trip_threshold),
   .core_reset_q                (core_reset_q),
   .shutdown_q                  (shutdown_q),
   .pins_hiz                    (pins_hiz),
   .pins_pullup_en              (pins_pullup_en),
   .host_port_select_lo         (host_port_select_lo),
   .host_port_select_hi         (host_port_select_hi),
   .host_port_q                 (host_port_q)
);
`default_nettype wire

// *** tb/rsc_reset_driver.sv ***
// External reset driver that pulls the reset pin low for a given count.
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_driver (
   input wire logic        clk,
   input wire logic        go,
   input wire logic [15:0] len,
   output wire logic       pull_low);
   logic [15:0] n_q = 16'h0;
   always @(posedge clk) n_q <= go ? len : (n_q != 16'h0 ? n_q - 16'h1 : n_q);
   assign pull_low = (n_q != 16'h0);
endmodule // rsc_reset_driver
`default_nettype wire

// *** tb/test_rsc_reset_combiner.sv ***
// Self-checking bench for the reset source combiner.
`timescale 1ns/10ps
`default_nettype none
module test_rsc_reset_combiner;
   logic clk = 0, rstn = 0, sup = 1, sd = 0, wk = 0, lo = 1, hi = 0, go = 0;
   logic [15:0] len = 16'h0;
   logic [1:0] hp;
   wire logic pin, oe, od, pl, cr, sq, hz, pu;
   int n_mismatch = 0, n_tests = 0, n;
   always #12.5 clk = !clk;
   // The pull-up gives a high level unless the device or the driver pulls low.
   assign pin = (oe ? od : 1'b1) && !pl;
   rsc_reset_combiner u_rsc_reset_combiner (.clk(clk), .rstn(rstn), .reset_pin_in(pin),
      .reset_pin_out(od), .reset_pin_oe(oe), .supply_above_trip_threshold(sup),
      .shutdown_req(sd), .wake_req(wk), .host_port_select_lo(lo), .host_port_select_hi(hi),
      .host_port_q(hp), .core_reset_q(cr), .shutdown_q(sq), .pins_hiz(hz), .pins_pullup_en(pu));
   rsc_reset_driver u_rsc_reset_driver (.clk(clk), .go(go), .len(len), .pull_low(pl));
   task wrap_up;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s exp %h got %h", nm, exp, got);
      end
   endtask
   task wait_cr(input logic v, input int lim);
      for (n = 0; n < lim && cr !== v; n++) @(negedge clk);
      if (cr !== v) begin
         n_mismatch++;
         $display("Error core reset wait exp %b got %b", v, cr);
         wrap_up();
      end
   endtask
   task pulse(input logic [15:0] l);
      len = l;
      go = 1;
      @(negedge clk);
      go = 0;
   endtask
   task t_power_up;
      repeat (10) @(negedge clk);
      rstn = 1;
      wait_cr(0, 4100);
      chk("power up delay", n >= 4000 && n <= 4010, 16'h1);
      chk("port", hp, 16'h2);
      chk("hiz run", hz, 16'h0);
      $display("power up test done");
   endtask
   task t_glitch;
      pulse(16'h00C8);
      repeat (10) @(negedge clk);
      chk("hiz", hz, 16'h1);
      chk("glitch pullup", pu, 16'h1);
      repeat (300) @(negedge clk);
      chk("glitch", cr, 16'h0);
      chk("hiz clear", hz, 16'h0);
      $display("glitch test done");
   endtask
   task t_shutdown_wake;
      sd = 1;
      wk = 1;
      repeat (20) @(negedge clk);
      sd = 0;
      repeat (20) @(negedge clk);
      chk("shutdown", sq, 16'h1);
      chk("shutdown core", cr, 16'h0);
      lo = 0;
      hi = 1;
      pulse(16'h01F4);
      wait_cr(1, 450);
      chk("ext delay", n >= 400, 16'h1);
      chk("pullup", pu, 16'h1);
      wait_cr(0, 4600);
      chk("wake", sq, 16'h0);
      chk("port", hp, 16'h1);
      wk = 0;
      $display("shutdown test done");
   endtask
   task t_dip;
      sup = 0;
      repeat (3) @(negedge clk);
      chk("dip", {oe, cr}, 16'h3);
      sup = 1;
      wait_cr(0, 4100);
      chk("dip delay", n >= 4000 && n <= 4010, 16'h1);
      chk("dip oe", oe, 16'h0);
      $display("dip test done");
   endtask
   initial begin
      t_power_up();
      t_glitch();
      t_shutdown_wake();
      t_dip();
      $display("scenarios done");
      wrap_up();
   end
endmodule // test_rsc_reset_combiner
`default_nettype wire
